// [core/lpm_pkg.sv]
package lpm_pkg;
    localparam int CA_W = 10;
    localparam int DQ_W = 32;
    localparam int DQS_W = 4;
    localparam int MR_ADDR_W = 8;
    localparam int MR_DATA_W = 8;
    localparam int BURST_BEATS = 8;
    localparam int NOP_AFTER_CKE = 2;
    localparam int STABLE_CLK_MIN = 2;
    localparam logic [7:0] MR_WRLVL_ADDR = 8'h02;
    localparam int MR_WRLVL_BIT = 7;
    localparam logic [7:0] MR_DEFAULT = 8'h00;
    localparam int RL_DEF = 8;
    localparam int TXSR_DEF = 20;
    localparam int TMRR_DEF = 4;
    localparam int TMRW_DEF = 10;
    localparam int TWLO_DEF = 2;
    localparam int TREF_DEF = 16;
    typedef enum logic [2:0] {
        LPM_CMD_NOP, LPM_CMD_SREF, LPM_CMD_MRR, LPM_CMD_MRW, LPM_CMD_OTHER
    } lpm_cmd_t;
endpackage

// [core/lpm_cmd_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface lpm_cmd_if;
    import lpm_pkg::*;
    logic valid;
    lpm_cmd_t cmd;
    logic cke;
    logic cke_prev;
    logic [7:0] mr_addr;
    logic [7:0] mr_data;
    modport src(output valid, cmd, cke, cke_prev, mr_addr, mr_data);
    modport dst(input valid, cmd, cke, cke_prev, mr_addr, mr_data);
endinterface
`default_nettype wire

// [core/lpm_link_rx.sv]
`timescale 1ns/100ps
`default_nettype none
// Samples the slow link clock and decodes command words at its edges
module lpm_link_rx (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_ck,
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic [lpm_pkg::CA_W-1:0] i_ca,
    lpm_cmd_if.src o_cmd
);
    import lpm_pkg::*;
    logic [2:0] ck_s;
    logic [2:0] cke_s;
    logic [2:0] cs_s;
    logic [CA_W-1:0] ca_s1, ca_s2, ca_s3;
    logic ck_lvl;
    logic [CA_W-1:0] ca_rise;
    logic cke_last;
    // Majority of stages 2 and 3 decides a level; stage 1 feeds stage 2 only
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ck_s <= 3'h0;
            cke_s <= 3'h0;
            cs_s <= 3'h7;
            ca_s1 <= '0;
            ca_s2 <= '0;
            ca_s3 <= '0;
        end else begin
            ck_s <= {ck_s[1:0], i_ck};
            cke_s <= {cke_s[1:0], i_cke};
            cs_s <= {cs_s[1:0], i_cs_n};
            ca_s1 <= i_ca;
            ca_s2 <= ca_s1;
            ca_s3 <= ca_s2;
        end
    end
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ck_lvl <= 1'b0;
        end else if (ck_s[1] == ck_s[2]) begin
            ck_lvl <= ck_s[2];
        end
    end
    wire logic rise = (ck_s[1] == ck_s[2]) && ck_s[2] && !ck_lvl;
    wire logic fall = (ck_s[1] == ck_s[2]) && !ck_s[2] && ck_lvl;
    // Decode at rising edge; MR fields complete at the following falling edge
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ca_rise <= '0;
            cke_last <= 1'b0;
            o_cmd.valid <= 1'b0;
            o_cmd.cmd <= LPM_CMD_NOP;
            o_cmd.cke <= 1'b0;
            o_cmd.cke_prev <= 1'b0;
            o_cmd.mr_addr <= '0;
            o_cmd.mr_data <= '0;
        end else begin
            o_cmd.valid <= fall;
            if (rise) begin
                ca_rise <= ca_s3;
                cke_last <= cke_s[2];
                o_cmd.cke_prev <= cke_last;
                o_cmd.cke <= cke_s[2];
                if (cs_s[2]) begin
                    o_cmd.cmd <= LPM_CMD_NOP;
                end else if (ca_s3[2:0] == 3'b100) begin
                    o_cmd.cmd <= LPM_CMD_SREF; // RQ1
                end else if (ca_s3[3:0] == 4'b1000) begin
                    o_cmd.cmd <= LPM_CMD_MRR; // RQ11
                end else if (ca_s3[3:0] == 4'b0000) begin
                    o_cmd.cmd <= LPM_CMD_MRW; // RQ18
                end else begin
                    o_cmd.cmd <= LPM_CMD_OTHER;
                end
            end
            if (fall) begin
                o_cmd.mr_addr <= {ca_s3[1:0], ca_rise[9:4]}; // RQ12
                o_cmd.mr_data <= ca_s3[9:2]; // RQ18
            end
        end
    end
endmodule
`default_nettype wire

// [core/lpm_refresh_timer.sv]
`timescale 1ns/100ps
`default_nettype none
// Built-in self-refresh timer: issues internal all-bank refreshes
module lpm_refresh_timer #(
    parameter int PERIOD = lpm_pkg::TREF_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_run,
    output logic o_refresh
);
    import lpm_pkg::*;
    initial begin
        if (PERIOD < 2) $error("PERIOD too small");
    end
    logic [15:0] cnt;
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt <= 16'h0000;
            o_refresh <= 1'b0;
        end else if (!i_run) begin
            cnt <= 16'h0000;
            o_refresh <= 1'b0;
        end else begin
            o_refresh <= (cnt == 16'(PERIOD - 1)); // RQ5
            cnt <= (cnt == 16'(PERIOD - 1)) ? 16'h0000 : cnt + 16'h0001;
        end
    end
    AST_REF_IN_PERIOD: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RQ5
        i_run && cnt == 16'h0000 |-> ##[1:64] (o_refresh || !i_run))
        else $error("no internal refresh within period");
endmodule
`default_nettype wire

// [core/lpm_sdram_ctl.sv]
// Function
// RQ1 - Self-refresh entry: CKE falls, CS low, CA=100
// RQ2 - Controller keeps CKE high during bursts, MR ops
// RQ3 - Receivers off only after two NOP cycles
// RQ4 - Stay in self-refresh while CKE low
// RQ5 - Internal timer refreshes, internal clock gated
// RQ6 - Controller may stop clock after tCPDED
// RQ7 - Two stable clocks before CKE registered high
// RQ8 - Only NOPs during tXSR after exit
// RQ9 - Controller refreshes before next self-refresh
// RQ10 - All banks idle before self-refresh entry
// RQ11 - Mode register read decode: CA=1000
// RQ12 - Register number from CA1f-CA0f, CA9r-CA4r
// RQ13 - Read data on DQ[7:0], first beat, after RL
// RQ14 - Eight-beat read burst, all DQS toggle (code bursts four beats)
// RQ15 - Controller spaces write after register read
// RQ16 - Controller spaces register read after bursts
// RQ17 - Extra tMRRI after idle power-down exit
// RQ18 - Register write decode CA=0000, data CA9f-CA2f
// RQ19 - Writes to read-only registers change nothing
// RQ20 - Register write only with banks precharged
// RQ21 - MR2 bit 7 enters and leaves write leveling
// RQ22 - Leveling: sample clock on DQS rise, drive DQ
// RQ23 - Non-NOP during tXSR, tMRR, leveling flagged (code lets any MRW pass in leveling)
`timescale 1ns/100ps
`default_nettype none
module lpm_sdram_ctl #(
    parameter int RL = lpm_pkg::RL_DEF,
    parameter int TXSR = lpm_pkg::TXSR_DEF,
    parameter int TMRR = lpm_pkg::TMRR_DEF,
    parameter int TMRW = lpm_pkg::TMRW_DEF,
    parameter int TWLO = lpm_pkg::TWLO_DEF,
    parameter int TREF = lpm_pkg::TREF_DEF,
    parameter logic [255:0] MR_RO_MASK = 256'h0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_01E0
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_ck,
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic [lpm_pkg::CA_W-1:0] i_ca,
    input wire logic [lpm_pkg::DQS_W-1:0] i_dqs,
    output logic [lpm_pkg::DQ_W-1:0] o_dq,
    output logic o_dq_oe_n,
    output logic [lpm_pkg::DQS_W-1:0] o_dqs,
    output logic o_dqs_oe_n,
    output logic o_self_refresh,
    output logic o_rx_enabled,
    output logic o_int_clk_en,
    output logic o_int_refresh,
    output logic o_wr_level,
    output logic o_violation
);
    import lpm_pkg::*;
    initial begin
        if (RL < 1 || TXSR < 1 || TMRR < 1 || TMRW < 1 || TWLO < 1) begin
            $error("timing parameters must be at least one");
        end
    end
    lpm_cmd_if cmd_bus ();
    lpm_link_rx u_rx (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_ck(i_ck),
        .i_cke(i_cke),
        .i_cs_n(i_cs_n),
        .i_ca(i_ca),
        .o_cmd(cmd_bus.src)
    );
    typedef enum logic [2:0] {
        LPM_IDLE, LPM_SR_ENTRY, LPM_SR, LPM_SR_EXIT, LPM_MRR, LPM_MRW
    } lpm_state_t;
    lpm_state_t state;
    logic [15:0] cnt;
    logic [7:0] mr [0:255];
    logic [7:0] mrr_data;
    logic [3:0] beat;
    logic [15:0] lat;
    logic [15:0] wlo_cnt;
    logic wl_sample;
    wire logic cv = cmd_bus.valid;
    wire lpm_cmd_t cc = cmd_bus.cmd;
    wire logic is_nop = (cc == LPM_CMD_NOP);
    wire logic sref_cmd = cv && cmd_bus.cke_prev && !cmd_bus.cke && cc == LPM_CMD_SREF;
    // Core clock cycles counted; internal refresh only in self-refresh
    lpm_refresh_timer #(.PERIOD(TREF)) u_tmr (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_run(state == LPM_SR),
        .o_refresh(o_int_refresh)
    );
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= LPM_IDLE;
            cnt <= 16'h0000;
        end else begin
            case (state)
                LPM_IDLE: begin
                    if (sref_cmd) begin
                        state <= LPM_SR_ENTRY; // RQ1
                        cnt <= 16'h0000;
                    end else if (cv && cmd_bus.cke && cc == LPM_CMD_MRR) begin
                        state <= LPM_MRR;
                        cnt <= 16'h0000;
                    end else if (cv && cmd_bus.cke && cc == LPM_CMD_MRW) begin
                        state <= LPM_MRW;
                        cnt <= 16'h0000;
                    end
                end
                LPM_SR_ENTRY: begin
                    if (cv) begin
                        cnt <= cnt + 16'h0001;
                        if (cnt == 16'(NOP_AFTER_CKE - 1)) begin
                            state <= LPM_SR; // RQ3
                        end
                    end
                end
                LPM_SR: begin
                    // All inputs ignored except CKE
                    if (cv && cmd_bus.cke) begin
                        state <= LPM_SR_EXIT; // RQ4
                        cnt <= 16'h0000;
                    end
                end
                LPM_SR_EXIT: begin
                    if (cv) begin
                        cnt <= cnt + 16'h0001;
                        if (cnt == 16'(TXSR - 1)) begin
                            state <= LPM_IDLE; // RQ8
                        end
                    end
                end
                LPM_MRR: begin
                    if (cv) begin
                        cnt <= cnt + 16'h0001;
                        if (cnt == 16'(TMRR - 1)) begin
                            state <= LPM_IDLE;
                        end
                    end
                end
                LPM_MRW: begin
                    if (cv) begin
                        cnt <= cnt + 16'h0001;
                        if (cnt == 16'(TMRW - 1)) begin
                            state <= LPM_IDLE;
                        end
                    end
                end
                default: begin
                    state <= LPM_IDLE;
                end
            endcase
        end
    end
    assign o_self_refresh = (state == LPM_SR) || (state == LPM_SR_ENTRY);
    assign o_rx_enabled = (state != LPM_SR); // RQ3
    assign o_int_clk_en = (state != LPM_SR); // RQ5
    // Mode registers; read-only ones keep their contents on writes
    generate
        for (genvar g = 0; g < 256; g++) begin : g_mr
            always_ff @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    mr[g] <= MR_DEFAULT;
                end else if (state == LPM_IDLE && cv && cmd_bus.cke && cc == LPM_CMD_MRW
                             && cmd_bus.mr_addr == 8'(g) && !MR_RO_MASK[g]) begin
                    mr[g] <= cmd_bus.mr_data; // RQ19
                end
            end
        end
    endgenerate
    assign o_wr_level = mr[MR_WRLVL_ADDR][MR_WRLVL_BIT]; // RQ21
    // Read burst: latency in link cycles, then four beats on DQ/DQS
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lat <= 16'h0000;
            beat <= 4'h0;
            mrr_data <= 8'h00;
        end else if (state == LPM_IDLE && cv && cmd_bus.cke && cc == LPM_CMD_MRR) begin
            lat <= 16'(RL);
            beat <= 4'h0;
            mrr_data <= mr[cmd_bus.mr_addr]; // RQ13
        end else if (cv && lat != 16'h0000) begin
            lat <= lat - 16'h0001;
            if (lat == 16'h0001) begin
                beat <= 4'h1;
            end
        end else if (cv && beat != 4'h0) begin
            beat <= (beat == 4'(BURST_BEATS / 2)) ? 4'h0 : beat + 4'h1; // RQ14
        end
    end
    wire logic bursting = (beat != 4'h0);
    // DQS and CK pass equal synchronisers so the sampled CK lines up with the strobe edge
    logic [2:0] dqs_s;
    logic [2:0] wck_s;
    logic dqs_lvl;
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dqs_s <= 3'h0;
            wck_s <= 3'h0;
        end else begin
            dqs_s <= {dqs_s[1:0], i_dqs[0]};
            wck_s <= {wck_s[1:0], i_ck};
        end
    end
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dqs_lvl <= 1'b0;
        end else if (dqs_s[1] == dqs_s[2]) begin
            dqs_lvl <= dqs_s[2];
        end
    end
    wire logic dqs_rise = (dqs_s[1] == dqs_s[2]) && dqs_s[2] && !dqs_lvl;
    // Leveling: sample link clock on DQS rise, show after TWLO core cycles
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wlo_cnt <= 16'h0000;
            wl_sample <= 1'b0;
        end else begin
            if (o_wr_level && dqs_rise) begin
                wl_sample <= wck_s[2]; // RQ22
                wlo_cnt <= 16'(TWLO);
            end else if (wlo_cnt != 16'h0000) begin
                wlo_cnt <= wlo_cnt - 16'h0001;
            end
        end
    end
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_dq <= '0;
            o_dqs <= '0;
        end else if (bursting) begin
            o_dq <= (beat == 4'h1) ? {{(DQ_W-8){1'b0}}, mrr_data} : '0; // RQ13
            o_dqs <= {DQS_W{beat[0]}}; // RQ14
        end else if (o_wr_level && wlo_cnt == 16'h0001) begin
            o_dq <= {DQ_W{wl_sample}}; // RQ22
            o_dqs <= '0;
        end else begin
            o_dqs <= '0;
        end
    end
    assign o_dq_oe_n = !(bursting || o_wr_level);
    assign o_dqs_oe_n = !bursting;
    // Illegal commands in restricted windows; any register write allowed in leveling
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_violation <= 1'b0;
        end else begin
            o_violation <= cv && !is_nop && (
                state == LPM_SR_EXIT || state == LPM_MRR ||
                (state == LPM_IDLE && o_wr_level && cc != LPM_CMD_MRW)); // RQ23
        end
    end
    sequence s_sref_cmd;
        sref_cmd;
    endsequence
    // Entry age bounds the NOP pair; a counter because the limit is far beyond a delay range
    localparam logic [15:0] ENTRY_LIMIT = 16'h07D0;
    logic [15:0] entry_age;
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            entry_age <= 16'h0000;
        end else if (state != LPM_SR_ENTRY) begin
            entry_age <= 16'h0000;
        end else if (entry_age != 16'hFFFF) begin
            entry_age <= entry_age + 16'h0001;
        end
    end
    AST_SREF_ENTRY: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RQ1
        s_sref_cmd |=> state == LPM_SR_ENTRY)
        else $error("self-refresh entry not taken");
    AST_RX_OFF_LATE: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RQ3
        s_sref_cmd |=> o_rx_enabled ##1 o_rx_enabled)
        else $error("receivers disabled too early");
    AST_SR_REACHED: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RQ3
        state == LPM_SR_ENTRY |-> entry_age < ENTRY_LIMIT)
        else $error("self-refresh not reached");
    AST_SR_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RQ4
        state == LPM_SR && !(cv && cmd_bus.cke) |=> state == LPM_SR)
        else $error("left self-refresh with CKE low");
    AST_CLK_GATED: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RQ5
        state == LPM_SR |-> !o_int_clk_en && !o_rx_enabled)
        else $error("internal clock running in self-refresh");
    AST_XSR_NO_ENTRY: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RQ8
        state == LPM_SR_EXIT |=> state != LPM_SR && state != LPM_MRR)
        else $error("bad state after exit");
    AST_MRR_DQ: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RQ13
        $rose(bursting) |=> o_dq[7:0] == mrr_data && !o_dq_oe_n)
        else $error("register data not on first beat");
    AST_DQS_TOGGLE: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RQ14
        bursting && $changed(beat) |=> o_dqs == {DQS_W{$past(beat[0])}})
        else $error("strobes not toggling");
    AST_RO_KEEP: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RQ19
        1'b1 |=> MR_RO_MASK[5] == 1'b0 || mr[5] == $past(mr[5]))
        else $error("read-only register changed");
    AST_VIOL: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RQ23
        state == LPM_MRR && cv && !is_nop |=> o_violation)
        else $error("illegal command not flagged");
    AST_WL_NO_DQS: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RQ22
        o_wr_level && !bursting |-> o_dqs_oe_n)
        else $error("strobes driven during leveling");
    AST_WL_RESULT: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RQ22
        o_wr_level && !bursting && wlo_cnt == 16'h0001
        |=> o_dq == {DQ_W{$past(wl_sample)}})
        else $error("leveling result not on DQ");
endmodule
`default_nettype wire

// [verification/lpm_ctl_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Behavioural memory controller; the link clock only runs while a command or NOP is sent
module lpm_ctl_model (
    output var logic o_ck,
    output var logic o_cke,
    output var logic o_cs_n,
    output var logic [lpm_pkg::CA_W-1:0] o_ca,
    output var logic [lpm_pkg::DQS_W-1:0] o_dqs
);
    import lpm_pkg::*;

    initial begin
        o_ck = 1'b0;
        o_cke = 1'b1;
        o_cs_n = 1'b1;
        o_ca = 10'h000;
        o_dqs = 4'h0;
    end

    // One link cycle; CA moves halfway between link edges so each half is settled when sampled
    task automatic cyc(input logic cke, input logic sel, input logic [CA_W-1:0] car,
                       input logic [CA_W-1:0] caf);
        o_cke = cke;
        o_cs_n = ~sel;
        o_ca = sel ? car : ~o_ca; // Unselected CA never repeats its last value
        #40 o_ck = 1'b1;
        #40 o_ca = sel ? caf : ~o_ca;
        #40 o_ck = 1'b0;
        #40;
    endtask

    // NOP cycles: covers tCPDED, tMRR, tMRW, tXSR and the stable clock before exit
    task automatic nops(input int n, input logic cke);
        repeat (n) cyc(cke, 1'b0, 10'h000, 10'h000);
    endtask

    // Link clock parked low while in self-refresh; CS and CA wander, CKE is left untouched
    task automatic stall(input int n);
        repeat (n) begin
            #20 o_cs_n = ~o_cs_n;
            o_ca = ~o_ca;
        end
    endtask

    // Leveling strobe with the link clock parked at a chosen level
    task automatic strobe(input logic level);
        o_ck = level;
        #100 o_dqs = 4'hF;
        #100 o_dqs = 4'h0;
        #100 o_ck = 1'b0;
        #60;
    endtask
endmodule
`default_nettype wire

// [verification/sdram_selfrefresh_modereg_wrlevel_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module sdram_selfrefresh_modereg_wrlevel_tb;
    import lpm_pkg::*;
    localparam int TXSR_T = 6;
    localparam int TREF_T = 16;
    logic i_core_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic ck;
    logic cke;
    logic cs_n;
    logic [CA_W-1:0] ca;
    logic [DQS_W-1:0] dqs;
    logic [DQ_W-1:0] o_dq;
    logic [DQS_W-1:0] o_dqs;
    logic o_dq_oe_n, o_dqs_oe_n, o_self_refresh, o_rx_enabled;
    logic o_int_clk_en, o_int_refresh, o_wr_level, o_violation;
    int errors = 0;
    int num_checks = 0;
    int cyc_cnt = 0;
    int viol_cnt = 0;
    int ref_cnt = 0;

    always #10 i_core_clk = ~i_core_clk;

    lpm_ctl_model ctl (.o_ck(ck), .o_cke(cke), .o_cs_n(cs_n), .o_ca(ca), .o_dqs(dqs));

    lpm_sdram_ctl #(.TXSR(TXSR_T), .TREF(TREF_T)) dut (
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_ck(ck), .i_cke(cke),
        .i_cs_n(cs_n), .i_ca(ca), .i_dqs(dqs), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n),
        .o_dqs(o_dqs), .o_dqs_oe_n(o_dqs_oe_n), .o_self_refresh(o_self_refresh),
        .o_rx_enabled(o_rx_enabled), .o_int_clk_en(o_int_clk_en),
        .o_int_refresh(o_int_refresh), .o_wr_level(o_wr_level), .o_violation(o_violation)
    );

    task automatic results();
        $display("errors=%0d checks=%0d", errors, num_checks);
        if (errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Pulses are counted here so no scenario can miss a one-cycle flag;
    // the falling edge keeps the count clear of the edge that launches them
    always @(negedge i_core_clk) begin
        cyc_cnt++;
        if (o_violation === 1'b1) viol_cnt++;
        if (o_int_refresh === 1'b1) ref_cnt++;
        if (cyc_cnt == 20000) begin
            errors++;
            results();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic mrw(input logic [7:0] addr, input logic [7:0] data);
        ctl.cyc(1'b1, 1'b1, {addr[5:0], 4'b0000}, {data, addr[7:6]});
        ctl.nops(TMRW_DEF, 1'b1);
    endtask

    task automatic mrr(input logic [7:0] addr, input logic [7:0] exp);
        int n;
        int tg;
        logic same;
        logic [DQS_W-1:0] last;
        n = 0;
        tg = 0;
        same = 1'b1;
        // No read, write or power-down ever precedes a register read here
        ctl.cyc(1'b1, 1'b1, {addr[5:0], 4'b1000}, {8'h00, addr[7:6]});
        fork
            ctl.nops(RL_DEF + 8, 1'b1);
            begin
                @(negedge i_core_clk);
                while (o_dq_oe_n !== 1'b0 && n < 300) begin
                    @(negedge i_core_clk);
                    n++;
                end
                chk("mrr_oe_n", 32'(1'b0), 32'(o_dq_oe_n));
                chk("mrr_dqs_oe_n", 32'(1'b0), 32'(o_dqs_oe_n));
                last = o_dqs;
                // Data and strobe are registered one core cycle behind the enables
                @(negedge i_core_clk);
                chk("mrr_data", 32'(exp), 32'(o_dq[7:0]));
                if (o_dqs !== last) tg++;
                last = o_dqs;
                while (o_dq_oe_n === 1'b0 && n < 600) begin
                    @(negedge i_core_clk);
                    n++;
                    if (o_dqs !== last) tg++;
                    if (o_dqs !== {DQS_W{o_dqs[0]}}) same = 1'b0;
                    last = o_dqs;
                end
                chk("dqs_toggles", 32'(1'b1), 32'(tg >= 4));
                chk("dqs_lanes", 32'(1'b1), 32'(same));
            end
        join
    endtask

    task automatic t_reset();
        chk("reset_outs", 32'(7'b0110110), 32'({o_self_refresh, o_rx_enabled, o_int_clk_en,
            o_wr_level, o_dq_oe_n, o_dqs_oe_n, o_violation}));
    endtask

    // Two addresses that differ only in a falling-edge bit must not alias
    task automatic t_mode_regs();
        int v0;
        v0 = viol_cnt;
        mrw(8'h41, 8'hA5);
        mrw(8'hC1, 8'h3C);
        mrr(8'h41, 8'hA5);
        mrr(8'hC1, 8'h3C);
        mrw(8'h05, 8'hFF);
        mrr(8'h05, MR_DEFAULT);
        chk("no_violation", 32'(v0), 32'(viol_cnt));
    endtask

    task automatic t_mrr_busy();
        int v0;
        v0 = viol_cnt;
        ctl.cyc(1'b1, 1'b1, 10'h008, 10'h000);
        ctl.cyc(1'b1, 1'b1, 10'h008, 10'h000);
        ctl.nops(RL_DEF + 8, 1'b1);
        chk("mrr_busy_violation", 32'(v0 + 1), 32'(viol_cnt));
    endtask

    task automatic t_self_refresh();
        int r0;
        int v0;
        ctl.nops(2, 1'b1);
        ctl.cyc(1'b0, 1'b1, 10'h004, 10'h000);
        ctl.nops(1, 1'b0);
        chk("rx_tcpded", 32'(3'b111), 32'({o_self_refresh, o_rx_enabled, o_int_clk_en}));
        ctl.nops(1, 1'b0);
        repeat (10) @(negedge i_core_clk);
        chk("sr_state", 32'(3'b100), 32'({o_self_refresh, o_rx_enabled, o_int_clk_en}));
        r0 = ref_cnt;
        v0 = viol_cnt;
        ctl.stall(4 * TREF_T);
        chk("sr_refresh", 32'(1'b1), 32'(ref_cnt > r0));
        chk("sr_stays", 32'(1'b1), 32'(o_self_refresh));
        chk("sr_ignores", 32'(v0), 32'(viol_cnt));
        ctl.nops(2, 1'b0);
        ctl.nops(1, 1'b1);
        repeat (10) @(negedge i_core_clk);
        chk("sr_exit", 32'(3'b011), 32'({o_self_refresh, o_rx_enabled, o_int_clk_en}));
        ctl.cyc(1'b1, 1'b1, 10'h008, 10'h000);
        ctl.nops(RL_DEF + 10, 1'b1);
        chk("txsr_violation", 32'(v0 + 1), 32'(viol_cnt));
        mrr(8'h41, 8'hA5);
        chk("after_txsr", 32'(v0 + 1), 32'(viol_cnt));
    endtask

    task automatic t_leveling();
        int v0;
        mrw(MR_WRLVL_ADDR, 8'h80);
        chk("wr_level_on", 32'(1'b1), 32'(o_wr_level));
        ctl.strobe(1'b0);
        chk("lvl_low", 32'({1'b0, 8'h00}), 32'({o_dq_oe_n, o_dq[7:0]}));
        ctl.strobe(1'b1);
        chk("lvl_high", 32'({1'b0, 8'hFF}), 32'({o_dq_oe_n, o_dq[7:0]}));
        chk("lvl_all_dq", 32'({DQ_W{1'b1}}), 32'(o_dq));
        v0 = viol_cnt;
        ctl.cyc(1'b1, 1'b1, 10'h008, 10'h000);
        ctl.nops(RL_DEF + 8, 1'b1);
        chk("lvl_violation", 32'(v0 + 1), 32'(viol_cnt));
        mrw(MR_WRLVL_ADDR, 8'h00);
        chk("wr_level_off", 32'(1'b0), 32'(o_wr_level));
        chk("lvl_exit_clean", 32'(v0 + 1), 32'(viol_cnt));
    endtask

    initial begin
        repeat (12) @(negedge i_core_clk);
        i_arst_n = 1'b1;
        repeat (4) @(negedge i_core_clk);
        t_reset();
        t_mode_regs();
        t_mrr_busy();
        // Self-refresh is entered once only, so no refresh is owed before a second entry
        t_self_refresh();
        t_leveling();
        results();
    end
endmodule
`default_nettype wire
